// ==== rtl/csf_pkg.sv ====
package csf_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_BUS_COND    = 8'h22;
	localparam logic [7:0] OFS_RSVD_A      = 8'h23;
	localparam logic [7:0] OFS_REC_FLAGS   = 8'h24;
	localparam logic [7:0] OFS_PLAY_PWR    = 8'h25;
	localparam logic [7:0] OFS_PLAY_GAIN   = 8'h26;
	localparam logic [7:0] OFS_OVF         = 8'h27;
	localparam logic [7:0] OFS_RSVD_BLK_LO = 8'h28;
	localparam logic [7:0] OFS_RSVD_BLK_HI = 8'h2B;
	localparam logic [7:0] OFS_PLAY_EVT    = 8'h2C;
	localparam logic [7:0] OFS_REC_EVT     = 8'h2D;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_GC_EN         = 5;
	localparam int BIT_REC_PGA_EQ    = 7;
	localparam int BIT_REC_ADC_UP    = 6;
	localparam int BIT_REC_SAT       = 5;
	localparam int BIT_DAC_UP        = 7;
	localparam int BIT_HP_UP         = 5;
	localparam int BIT_SPK_UP        = 4;
	localparam int BIT_PLAY_PGA_EQ   = 4;
	localparam int BIT_OVF_DAC       = 7;
	localparam int BIT_OVF_PLAY_SH   = 5;
	localparam int BIT_OVF_ADC       = 3;
	localparam int BIT_OVF_REC_SH    = 1;
	localparam int BIT_SHORT         = 7;
	localparam int BIT_BUTTON        = 5;
	localparam int BIT_PLUG          = 4;
	localparam int BIT_DRC_ABOVE     = 3;
	localparam int BIT_PLAY_IRQ_STD  = 1;
	localparam int BIT_PLAY_IRQ_AUX  = 0;
	localparam int BIT_AGC_NOISE     = 6;
	localparam int BIT_REC_IRQ_STD   = 4;
	localparam int BIT_REC_IRQ_AUX   = 3;
	localparam int BIT_DC_AVAIL      = 2;

	// ****************************************************************
	// Writable bit masks and reset values
	// ****************************************************************
	localparam logic [7:0] WMASK_BUS_COND  = 8'hFF;
	localparam logic [7:0] WMASK_REC_FLAGS = 8'h1F;
	localparam logic [7:0] WMASK_OVF       = 8'h05;
	localparam logic [7:0] WMASK_REC_EVT   = 8'h83;
	localparam logic [7:0] RST_BYTE        = 8'h00;
	localparam logic [3:0] RST_OVF_STICKY  = 4'h0;
	localparam int         RSVD_BLK_N      = 4;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS   = 20;
	localparam int INT_PULSE_NS    = 2000000;
	localparam int INT_PERIOD_NS   = 4000000;
	localparam int INT_PULSE_CYC   = INT_PULSE_NS / CLK_PERIOD_NS;
	localparam int INT_PERIOD_CYC  = INT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CNT_W           = 18;
	localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;
	localparam int GAIN_W          = 7;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic              rec_pga_eq;
		logic              rec_adc_up;
		logic              dac_up;
		logic              hp_up;
		logic              spk_up;
		logic              play_pga_eq;
		logic              ovf_dac;
		logic              ovf_play_sh;
		logic              ovf_adc;
		logic              ovf_rec_sh;
		logic              short_det;
		logic              button;
		logic              plug;
		logic              drc_above;
		logic              play_irq_std;
		logic              play_irq_aux;
		logic              agc_noise_low;
		logic              rec_irq_std;
		logic              rec_irq_aux;
		logic              dc_avail;
		logic [GAIN_W-1:0] agc_gain_applied;
		logic [GAIN_W-1:0] agc_gain_max;
	} csf_stat_t;

	localparam csf_stat_t STAT_RST = '0;

	typedef struct packed {
		logic       gc;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csf_req_t;

	localparam csf_req_t REQ_RST = '0;

	typedef enum logic [1:0] {
		INT_IDLE,
		INT_HIGH,
		INT_LOW
	} csf_int_st_t;

endpackage

// ==== rtl/csf_regs.sv ====
`timescale 1ns/1ps
// Summary of operation
// - General-call transfers accepted only when enabled.
// - Record gain-settled status bit, read-only.
// - Record converter power state, read-only.
// - Saturation flag when applied gain equals maximum.
// - Saturation flag sticky, cleared by reading.
// - Playback converter power state, read-only.
// - Headphone and speaker driver power bits.
// - Playback gain-settled status bit, read-only.
// - Converter overflow flags for both paths.
// - Barrel-shifter overflow flags for both paths.
// - Short-circuit flag mirrors detector level.
// - Headset button flag, undefined reset.
// - Headset plug-change flag, undefined reset.
// - Compressor threshold exceeded flag.
// - Playback engine interrupt ports mirrored.
// - Record noise-threshold flag.
// - Record engine interrupt ports mirrored.
// - DC measurement availability bit.
// - Repeated interrupt pulses until both event registers read.
module csf_regs #(
	parameter int INT_PULSE  = csf_pkg::INT_PULSE_CYC,    // Pulse width in cycles
	parameter int INT_PERIOD = csf_pkg::INT_PERIOD_CYC    // Pulse period in cycles
) (
	input  wire logic              clk_sys_i,    // System clock, 50 MHz
	input  wire logic              srst_i,       // Synchronous reset, active high
	input  wire logic              clk_link_i,   // Control link clock
	input  wire logic              lnk_req_i,    // Link request strobe
	input  wire csf_pkg::csf_req_t lnk_cmd_i,    // Link request contents
	output logic                   lnk_busy_o,   // Request in flight
	output logic                   lnk_done_o,   // Answer strobe
	output logic                   lnk_ack_o,    // Request was accepted
	output logic [7:0]             lnk_rdata_o,  // Read data
	input  wire csf_pkg::csf_stat_t stat_i,      // Status from other domains
	input  wire logic              first_interrupt_output_evt_i,   // Interrupt trigger, system clock
	input  wire logic              first_interrupt_output_repeat_i, // Repeated pulse mode
	output logic                   first_interrupt_output_o,       // first_interrupt_output
	output logic                   gc_en_o       // General-call enable
);

	// ****************************************************************
	// Link domain: reset sync, request capture, answer return
	// ****************************************************************
	logic              lrst_s1_reg;
	logic              lrst_s2_reg;
	csf_pkg::csf_req_t req_hold_reg;
	logic              req_tgl_reg;
	logic              busy_reg;
	logic              rsp_s1_reg;
	logic              rsp_s2_reg;
	logic              rsp_s3_reg;
	logic              done_reg;
	logic              ack_reg;
	logic [7:0]        rdata_reg;
	logic              rsp_tgl_reg;
	logic              rsp_ack_reg;
	logic [7:0]        rsp_data_reg;
	wire               req_take = lnk_req_i & ~busy_reg;
	wire               rsp_seen = rsp_s2_reg ^ rsp_s3_reg;

	always_ff @(posedge clk_link_i) begin
		lrst_s1_reg <= srst_i;
		lrst_s2_reg <= lrst_s1_reg;
	end

	always_ff @(posedge clk_link_i) begin
		if (lrst_s2_reg) begin
			req_hold_reg <= csf_pkg::REQ_RST;
			req_tgl_reg  <= 1'b0;
			busy_reg     <= 1'b0;
			rsp_s1_reg   <= 1'b0;
			rsp_s2_reg   <= 1'b0;
			rsp_s3_reg   <= 1'b0;
			done_reg     <= 1'b0;
			ack_reg      <= 1'b0;
			rdata_reg    <= csf_pkg::RST_BYTE;
		end else begin
			rsp_s1_reg <= rsp_tgl_reg;
			rsp_s2_reg <= rsp_s1_reg;
			rsp_s3_reg <= rsp_s2_reg;
			done_reg   <= rsp_seen;
			if (req_take) begin
				req_hold_reg <= lnk_cmd_i;
				req_tgl_reg  <= ~req_tgl_reg;
				busy_reg     <= 1'b1;
			end else if (rsp_seen) begin
				busy_reg <= 1'b0;
			end
			if (rsp_seen) begin
				ack_reg   <= rsp_ack_reg;
				rdata_reg <= rsp_data_reg;
			end
		end
	end

	assign lnk_busy_o  = busy_reg;
	assign lnk_done_o  = done_reg;
	assign lnk_ack_o   = ack_reg;
	assign lnk_rdata_o = rdata_reg;

	// ****************************************************************
	// System domain: synchronisers
	// ****************************************************************
	csf_pkg::csf_stat_t stat_s1_reg;
	csf_pkg::csf_stat_t st;
	logic               req_s1_reg;
	logic               req_s2_reg;
	logic               req_s3_reg;
	csf_pkg::csf_stat_t st_prev_reg;
	logic               st_fill1_reg;
	logic               st_fill2_reg;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			stat_s1_reg <= csf_pkg::STAT_RST;
			st          <= csf_pkg::STAT_RST;
			st_prev_reg  <= csf_pkg::STAT_RST;
			st_fill1_reg <= 1'b0;
			st_fill2_reg <= 1'b0;
			req_s1_reg  <= 1'b0;
			req_s2_reg  <= 1'b0;
			req_s3_reg  <= 1'b0;
		end else begin
			stat_s1_reg <= stat_i;
			st          <= stat_s1_reg;
			st_prev_reg  <= st;
			st_fill1_reg <= 1'b1;
			st_fill2_reg <= st_fill1_reg;
			req_s1_reg  <= req_tgl_reg;
			req_s2_reg  <= req_s1_reg;
			req_s3_reg  <= req_s2_reg;
		end
	end

	// ****************************************************************
	// Access decode
	// ****************************************************************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	logic [7:0] bus_cond_reg;
	logic [7:0] rsvd_a_reg;
	logic [7:0] rsvd_blk_reg [csf_pkg::RSVD_BLK_N];
	logic [7:0] rec_rsvd_reg;
	logic [7:0] ovf_rsvd_reg;
	logic [7:0] rec_evt_rsvd_reg;
	logic       sat_reg;
	logic [3:0] ovf_reg;

	wire       acc_go   = req_s2_reg ^ req_s3_reg;
	wire [7:0] acc_addr = req_hold_reg.addr;
	wire       acc_ok   = ~req_hold_reg.gc | bus_cond_reg[csf_pkg::BIT_GC_EN];
	wire       wr_en    = acc_go & acc_ok & req_hold_reg.wr;
	wire       rd_en    = acc_go & acc_ok & ~req_hold_reg.wr;
	wire [7:0] wd       = req_hold_reg.wdata;
	wire       in_blk   = (acc_addr >= csf_pkg::OFS_RSVD_BLK_LO) & (acc_addr <= csf_pkg::OFS_RSVD_BLK_HI);
	wire [1:0] blk_idx  = acc_addr[1:0];

	// ****************************************************************
	// Live status and sticky flags
	// ****************************************************************
	// Gain words cross without a handshake: only trust them once the
	// pipeline holds real samples and the words stood still for a cycle
	wire       gain_ok  = st_fill2_reg
	                      & (st.agc_gain_applied == st_prev_reg.agc_gain_applied)
	                      & (st.agc_gain_max == st_prev_reg.agc_gain_max);
	wire       sat_live = gain_ok & (st.agc_gain_applied == st.agc_gain_max);
	wire       rd_rec   = rd_en & hit(acc_addr, csf_pkg::OFS_REC_FLAGS);
	wire       rd_ovf   = rd_en & hit(acc_addr, csf_pkg::OFS_OVF);
	wire       sat_next = sat_live | (sat_reg & ~rd_rec);
	wire [3:0] ovf_live = {st.ovf_dac, st.ovf_play_sh, st.ovf_adc, st.ovf_rec_sh};
	wire [3:0] ovf_next = ovf_live | (ovf_reg & {4{~rd_ovf}});

	// Read-only bits are only ever assembled here, so writes cannot reach them
	wire [7:0] v_rec = ({st.rec_pga_eq, st.rec_adc_up, sat_reg, 5'h00}
	                    | (rec_rsvd_reg & csf_pkg::WMASK_REC_FLAGS));
	wire [7:0] v_pwr = {st.dac_up, 1'b0, st.hp_up, st.spk_up, 4'h0};
	wire [7:0] v_gain = {3'h0, st.play_pga_eq, 4'h0};
	wire [7:0] v_ovf = ({ovf_reg[3], 1'b0, ovf_reg[2], 1'b0, ovf_reg[1], 1'b0, ovf_reg[0], 1'b0}
	                    | (ovf_rsvd_reg & csf_pkg::WMASK_OVF));
	wire [7:0] v_pevt = {st.short_det, 1'b0, st.button, st.plug, st.drc_above,
	                     1'b0, st.play_irq_std, st.play_irq_aux};
	wire [7:0] v_revt = ({1'b0, st.agc_noise_low, 1'b0, st.rec_irq_std,
	                      st.rec_irq_aux, st.dc_avail, 2'h0}
	                     | (rec_evt_rsvd_reg & csf_pkg::WMASK_REC_EVT));

	wire [7:0] rd_mux =
		hit(acc_addr, csf_pkg::OFS_BUS_COND)  ? bus_cond_reg :
		hit(acc_addr, csf_pkg::OFS_RSVD_A)    ? rsvd_a_reg :
		hit(acc_addr, csf_pkg::OFS_REC_FLAGS) ? v_rec :
		hit(acc_addr, csf_pkg::OFS_PLAY_PWR)  ? v_pwr :
		hit(acc_addr, csf_pkg::OFS_PLAY_GAIN) ? v_gain :
		hit(acc_addr, csf_pkg::OFS_OVF)       ? v_ovf :
		in_blk                                ? rsvd_blk_reg[blk_idx] :
		hit(acc_addr, csf_pkg::OFS_PLAY_EVT)  ? v_pevt :
		hit(acc_addr, csf_pkg::OFS_REC_EVT)   ? v_revt :
		csf_pkg::RST_BYTE;

	// ****************************************************************
	// Register storage
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			bus_cond_reg     <= csf_pkg::RST_BYTE;
			rsvd_a_reg       <= csf_pkg::RST_BYTE;
			rec_rsvd_reg     <= csf_pkg::RST_BYTE;
			ovf_rsvd_reg     <= csf_pkg::RST_BYTE;
			rec_evt_rsvd_reg <= csf_pkg::RST_BYTE;
			sat_reg          <= 1'b0;
			ovf_reg          <= csf_pkg::RST_OVF_STICKY;
		end else begin
			sat_reg <= sat_next;
			ovf_reg <= ovf_next;
			if (wr_en & hit(acc_addr, csf_pkg::OFS_BUS_COND))
				bus_cond_reg <= wd & csf_pkg::WMASK_BUS_COND;
			if (wr_en & hit(acc_addr, csf_pkg::OFS_RSVD_A))
				rsvd_a_reg <= wd;
			if (wr_en & hit(acc_addr, csf_pkg::OFS_REC_FLAGS))
				rec_rsvd_reg <= wd & csf_pkg::WMASK_REC_FLAGS;
			if (wr_en & hit(acc_addr, csf_pkg::OFS_OVF))
				ovf_rsvd_reg <= wd & csf_pkg::WMASK_OVF;
			if (wr_en & hit(acc_addr, csf_pkg::OFS_REC_EVT))
				rec_evt_rsvd_reg <= wd & csf_pkg::WMASK_REC_EVT;
		end
	end

	genvar g;
	generate
		for (g = 0; g < csf_pkg::RSVD_BLK_N; g++) begin : g_blk
			always_ff @(posedge clk_sys_i) begin
				if (srst_i)
					rsvd_blk_reg[g] <= csf_pkg::RST_BYTE;
				else if (wr_en & in_blk & (blk_idx == 2'(g)))
					rsvd_blk_reg[g] <= wd;
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rsp_tgl_reg  <= 1'b0;
			rsp_ack_reg  <= 1'b0;
			rsp_data_reg <= csf_pkg::RST_BYTE;
		end else if (acc_go) begin
			rsp_tgl_reg  <= ~rsp_tgl_reg;
			rsp_ack_reg  <= acc_ok;
			rsp_data_reg <= rd_en ? rd_mux : csf_pkg::RST_BYTE;
		end
	end

	assign gc_en_o = bus_cond_reg[csf_pkg::BIT_GC_EN];

	// ****************************************************************
	// Interrupt pulse generator
	// ****************************************************************
	localparam logic [csf_pkg::CNT_W-1:0] PULSE_LAST = csf_pkg::CNT_W'(INT_PULSE - 1);
	localparam logic [csf_pkg::CNT_W-1:0] LOW_LAST   = csf_pkg::CNT_W'(INT_PERIOD - INT_PULSE - 1);

	csf_pkg::csf_int_st_t         int_st_reg;
	csf_pkg::csf_int_st_t         int_st_next;
	logic [csf_pkg::CNT_W-1:0]    int_cnt_reg;
	logic                         seen_p_reg;
	logic                         seen_r_reg;
	logic                         first_interrupt_output_reg;

	wire rd_pevt   = rd_en & hit(acc_addr, csf_pkg::OFS_PLAY_EVT);
	wire rd_revt   = rd_en & hit(acc_addr, csf_pkg::OFS_REC_EVT);
	wire both_read = seen_p_reg & seen_r_reg;
	wire cnt_end   = (int_st_reg == csf_pkg::INT_HIGH) ? (int_cnt_reg == PULSE_LAST) : (int_cnt_reg == LOW_LAST);
	wire again     = first_interrupt_output_repeat_i & ~both_read;

	always_comb begin
		int_st_next = int_st_reg;
		unique case (int_st_reg)
			csf_pkg::INT_IDLE: begin
				if (first_interrupt_output_evt_i)
					int_st_next = csf_pkg::INT_HIGH;
			end
			csf_pkg::INT_HIGH: begin
				if (cnt_end)
					int_st_next = again ? csf_pkg::INT_LOW : csf_pkg::INT_IDLE;
			end
			csf_pkg::INT_LOW: begin
				if (first_interrupt_output_evt_i)
					int_st_next = csf_pkg::INT_HIGH;
				else if (both_read)
					int_st_next = csf_pkg::INT_IDLE;
				else if (cnt_end)
					int_st_next = csf_pkg::INT_HIGH;
			end
			default: int_st_next = csf_pkg::INT_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			int_st_reg  <= csf_pkg::INT_IDLE;
			int_cnt_reg <= csf_pkg::CNT_ZERO;
			seen_p_reg  <= 1'b0;
			seen_r_reg  <= 1'b0;
			first_interrupt_output_reg    <= 1'b0;
		end else begin
			int_st_reg  <= int_st_next;
			int_cnt_reg <= (int_st_next != int_st_reg) ? csf_pkg::CNT_ZERO : int_cnt_reg + 1'b1;
			seen_p_reg  <= ~first_interrupt_output_evt_i & (seen_p_reg | rd_pevt);
			seen_r_reg  <= ~first_interrupt_output_evt_i & (seen_r_reg | rd_revt);
			first_interrupt_output_reg    <= (int_st_next == csf_pkg::INT_HIGH);
		end
	end

	assign first_interrupt_output_o = first_interrupt_output_reg;

endmodule

// ==== verif/csf_regs_sva.sv ====
`timescale 1ns/1ps
// ********
// Checker
// ********
module csf_regs_sva #(
	parameter int INT_PULSE  = 4, // Pulse cycles
	parameter int INT_PERIOD = 8  // Period cycles
) (
	input  wire logic              clk_sys_i,     // System clock
	input  wire logic              srst_i,        // Reset
	input  wire logic              clk_link_i,    // Link clock
	input  wire logic              lnk_req_i,     // Request
	input  wire csf_pkg::csf_req_t lnk_cmd_i,     // Command
	input  wire logic              lnk_busy_o,    // Busy
	input  wire logic              lnk_done_o,    // Answer
	input  wire logic              lnk_ack_o,     // Accepted
	input  wire logic [7:0]        lnk_rdata_o,   // Read data
	input  wire logic              first_interrupt_output_evt_i,    // Trigger
	input  wire logic              first_interrupt_output_repeat_i, // Repeat mode
	input  wire logic              first_interrupt_output_o,        // Interrupt
	input  wire logic              gc_en_o        // Call enable
);
	int hi_cnt;
	int lo_cnt;

	// Length of the current high or low run of the interrupt
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			hi_cnt <= 0;
			lo_cnt <= 0;
		end else if (first_interrupt_output_o) begin
			hi_cnt <= hi_cnt + 1;
			lo_cnt <= 0;
		end else begin
			hi_cnt <= 0;
			lo_cnt <= lo_cnt + 1;
		end
	end

	sequence s_take;
		lnk_req_i && !lnk_busy_o;
	endsequence

	sequence s_refused;
		lnk_done_o && !lnk_ack_o && lnk_rdata_o == 8'h00;
	endsequence

	gc_refuse_a: assert property (@(posedge clk_link_i) disable iff (srst_i)
		s_take ##0 (lnk_cmd_i.gc && !gc_en_o) |-> ##[4:12] s_refused) else $error("general call not refused");
	gc_accept_a: assert property (@(posedge clk_link_i) disable iff (srst_i)
		s_take ##0 (lnk_cmd_i.gc && gc_en_o) |-> ##[4:12] (lnk_done_o && lnk_ack_o)) else $error("call refused");
	busy_hold_a: assert property (@(posedge clk_link_i) disable iff (srst_i)
		s_take |=> (lnk_busy_o && !lnk_done_o)[*3]) else $error("busy dropped early");
	answer_time_a: assert property (@(posedge clk_link_i) disable iff (srst_i)
		s_take |-> ##[4:12] lnk_done_o) else $error("no answer in time");
	done_pulse_a: assert property (@(posedge clk_link_i) disable iff (srst_i)
		lnk_done_o |-> !lnk_busy_o ##1 !lnk_done_o) else $error("bad answer strobe");
	write_data_a: assert property (@(posedge clk_link_i) disable iff (srst_i)
		s_take ##0 lnk_cmd_i.wr |-> ##[4:12] (lnk_done_o && lnk_rdata_o == 8'h00)) else $error("write data");
	int_start_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		first_interrupt_output_evt_i |=> first_interrupt_output_o) else $error("interrupt not started");
	pulse_width_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$fell(first_interrupt_output_o) |-> hi_cnt == INT_PULSE) else $error("pulse width wrong");
	pulse_gap_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$rose(first_interrupt_output_o) && !$past(first_interrupt_output_evt_i) |-> first_interrupt_output_repeat_i && lo_cnt == INT_PERIOD - INT_PULSE)
		else $error("pulse period wrong");
endmodule

bind csf_regs csf_regs_sva #(.INT_PULSE(INT_PULSE), .INT_PERIOD(INT_PERIOD)) u_sva (
	.clk_sys_i(clk_sys_i), .srst_i(srst_i), .clk_link_i(clk_link_i), .lnk_req_i(lnk_req_i),
	.lnk_cmd_i(lnk_cmd_i), .lnk_busy_o(lnk_busy_o), .lnk_done_o(lnk_done_o), .lnk_ack_o(lnk_ack_o),
	.lnk_rdata_o(lnk_rdata_o), .first_interrupt_output_evt_i(first_interrupt_output_evt_i), .first_interrupt_output_repeat_i(first_interrupt_output_repeat_i),
	.first_interrupt_output_o(first_interrupt_output_o), .gc_en_o(gc_en_o)
);

// ==== verif/csf_host.sv ====
`timescale 1ns/1ps
// ********
// Host controller model
// ********
module csf_host (
	input  wire logic         clk_link_i, // Link clock
	input  wire logic         busy_i,     // Request in flight
	input  wire logic         done_i,     // Answer strobe
	input  wire logic         ack_i,      // Accepted
	input  wire logic [7:0]   rdata_i,    // Read data
	output logic              req_o,      // Request strobe
	output csf_pkg::csf_req_t cmd_o       // Request contents
);
	initial begin
		req_o = 1'b0;
		cmd_o = csf_pkg::REQ_RST;
	end

	task automatic xfer(input logic gc, input logic wr, input logic [7:0] a, input logic [7:0] wd,
			output logic ack, output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge clk_link_i);
		#1;
		req_o = 1'b1;
		cmd_o.gc = gc;
		cmd_o.addr = a;
		cmd_o.wr = wr && !(a inside {8'h25, 8'h26});
		cmd_o.wdata = (a == 8'h22) ? (wd & 8'h20) : (a == 8'h2D) ? (wd & 8'h7C) : (a < 8'h2E) ? 8'h00 : wd;
		do @(posedge clk_link_i); while (busy_i && ++n < 40);
		#1;
		req_o = 1'b0;
		// Idle bus shows the last command inverted
		cmd_o = ~cmd_o;
		do @(posedge clk_link_i); while (!done_i && ++n < 40);
		ack = (n < 40) ? ack_i : 1'bX;
		rd = (n < 40) ? rdata_i : 8'hXX;
	endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %0t: got %h exp %h", $time, g, e); end end
module tb;
	// ********
	// Bench
	// ********
	logic               clk_sys_i  = 1'b0;
	logic               clk_link_i = 1'b0;
	logic               srst_i     = 1'b1;
	logic               lnk_req;
	csf_pkg::csf_req_t  lnk_cmd;
	logic               lnk_busy;
	logic               lnk_done;
	logic               lnk_ack;
	logic [7:0]         lnk_rdata;
	csf_pkg::csf_stat_t stat       = csf_pkg::STAT_RST;
	logic               evt        = 1'b0;
	logic               rpt        = 1'b0;
	logic               first_interrupt_output;
	logic               gc_en;
	int                 miscompares = 0;
	int                 checks_done = 0;
	int                 cycles      = 0;
	int                 rises       = 0;
	int                 snap;

	csf_regs #(.INT_PULSE(4), .INT_PERIOD(8)) dut (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .clk_link_i(clk_link_i), .lnk_req_i(lnk_req),
		.lnk_cmd_i(lnk_cmd), .lnk_busy_o(lnk_busy), .lnk_done_o(lnk_done), .lnk_ack_o(lnk_ack),
		.lnk_rdata_o(lnk_rdata), .stat_i(stat), .first_interrupt_output_evt_i(evt), .first_interrupt_output_repeat_i(rpt),
		.first_interrupt_output_o(first_interrupt_output), .gc_en_o(gc_en)
	);

	csf_host host (
		.clk_link_i(clk_link_i), .busy_i(lnk_busy), .done_i(lnk_done), .ack_i(lnk_ack),
		.rdata_i(lnk_rdata), .req_o(lnk_req), .cmd_o(lnk_cmd)
	);

	initial begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		#7;
		forever #32 clk_link_i = ~clk_link_i;
	end

	always @(posedge first_interrupt_output) rises++;

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic acc(input logic gc, input logic wr, input logic [7:0] a, input logic [7:0] wd,
			input logic [7:0] e, input logic ea);
		logic       ack_v;
		logic [7:0] rd_v;
		host.xfer(gc, wr, a, wd, ack_v, rd_v);
		`CHK(ack_v, ea)
		`CHK(rd_v, e)
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, 1'b0, a, 8'h00, e, 1'b1);
	endtask

	task automatic wr_do(input logic [7:0] a, input logic [7:0] d);
		acc(1'b0, 1'b1, a, d, 8'h00, 1'b1);
	endtask

	task automatic sys_wait(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic do_reset();
		srst_i = 1'b1;
		// Long enough for four link edges as well
		sys_wait(14);
		srst_i = 1'b0;
		repeat (5) @(posedge clk_link_i);
	endtask

	initial begin
		stat.agc_gain_max = 7'h7F;
		do_reset();
		for (int a = 8'h22; a <= 8'h2D; a++) rd_chk(a[7:0], 8'h00);
		acc(1'b1, 1'b1, 8'h22, 8'h20, 8'h00, 1'b0);
		rd_chk(8'h22, 8'h00);
		wr_do(8'h22, 8'hFF);
		rd_chk(8'h22, 8'h20);
		`CHK(gc_en, 1'b1)
		acc(1'b1, 1'b0, 8'h22, 8'h00, 8'h20, 1'b1);
		wr_do(8'h2D, 8'hFF);
		wr_do(8'h25, 8'hFF);
		wr_do(8'h40, 8'hA5);
		rd_chk(8'h40, 8'h00);
		rd_chk(8'h2D, 8'h00);
		stat = '1;
		stat.agc_gain_applied = 7'h00;
		stat.agc_gain_max = 7'h7F;
		sys_wait(4);
		rd_chk(8'h24, 8'hC0);
		rd_chk(8'h25, 8'hB0);
		rd_chk(8'h26, 8'h10);
		rd_chk(8'h27, 8'hAA);
		rd_chk(8'h2C, 8'hBB);
		rd_chk(8'h2D, 8'h5C);
		stat = csf_pkg::STAT_RST;
		stat.agc_gain_max = 7'h7F;
		sys_wait(4);
		rd_chk(8'h27, 8'hAA);
		rd_chk(8'h27, 8'h00);
		rd_chk(8'h2C, 8'h00);
		stat.agc_gain_applied = 7'h7E;
		sys_wait(4);
		rd_chk(8'h24, 8'h00);
		stat.agc_gain_applied = 7'h7F;
		sys_wait(6);
		stat.agc_gain_applied = 7'h00;
		sys_wait(4);
		rd_chk(8'h24, 8'h20);
		rd_chk(8'h24, 8'h00);
		sys_wait(1);
		evt = 1'b1;
		sys_wait(1);
		evt = 1'b0;
		sys_wait(20);
		`CHK(rises, 1)
		sys_wait(1);
		rpt = 1'b1;
		evt = 1'b1;
		sys_wait(1);
		evt = 1'b0;
		sys_wait(20);
		`CHK(rises, 4)
		rd_chk(8'h2C, 8'h00);
		rd_chk(8'h2D, 8'h00);
		sys_wait(6);
		snap = rises;
		sys_wait(40);
		`CHK(rises, snap)
		`CHK(first_interrupt_output, 1'b0)
		do_reset();
		`CHK(gc_en, 1'b0)
		rd_chk(8'h22, 8'h00);
		complete_run();
	end
endmodule
